// ===== core/sbam_pkg.sv
// Package for the SDRAM bank size register and address multiplexer
package sbam_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [31:0] BANK_SIZE_ADDR = 32'h0f000408;
    localparam logic [31:0] ADDR_MASK = 32'h00000ffc; // Decoded low bits
    localparam logic [31:0] BANK_SIZE_OFF = BANK_SIZE_ADDR & ADDR_MASK;
    localparam logic [31:0] STATUS_OFF = 32'h00000800;
    localparam int NUM_BANKS = 4;
    localparam int CODE_W = 3;
    localparam int FIELD_STRIDE = 4;
    localparam logic [15:0] WRITE_MASK = 16'h7777;
    // ****************************************************************
    // Size codes and reset values
    // ****************************************************************
    localparam logic [2:0] SIZE_8MB = 3'h2;
    localparam logic [2:0] SIZE_16MB = 3'h3;
    localparam logic [2:0] SIZE_32MB = 3'h4;
    localparam logic [2:0] SIZE_64MB = 3'h5;
    localparam logic [2:0] RESET_CODE_NARROW = SIZE_32MB;
    localparam logic [2:0] RESET_CODE_WIDE = SIZE_64MB;
    // Bank sizes in units of 8 MB
    localparam logic [3:0] UNITS_8MB = 4'h1;
    localparam logic [3:0] UNITS_16MB = 4'h2;
    localparam logic [3:0] UNITS_32MB = 4'h4;
    localparam logic [3:0] UNITS_64MB = 4'h8;
    // ****************************************************************
    // Bus responses and mux phase
    // ****************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        PH_IDLE = 2'h0,
        PH_ROW = 2'h1,
        PH_COL = 2'h3
    } sbam_phase_type;

    // Size code to bank size in 8 MB units; reserved codes give zero
    function automatic logic [3:0] sbam_units(input logic [2:0] code, input logic wide);
        logic [3:0] u;
        u = 4'h0;
        unique case (code)
            SIZE_8MB: u = UNITS_8MB;
            SIZE_16MB: u = UNITS_16MB;
            SIZE_32MB: u = UNITS_32MB;
            SIZE_64MB: u = wide ? UNITS_64MB : 4'h0;
            default: u = 4'h0;
        endcase
        return u;
    endfunction : sbam_units
endpackage : sbam_pkg

// ===== core/sbam_addr_mux.sv
// Row and column mapping of the physical address onto the SDRAM pins
`timescale 1ns/100ps
module sbam_addr_mux
    import sbam_pkg::*;
(
    // Address source
    input wire logic [25:1] physAddr,
    input wire logic wideBusSelect,
    input wire logic precharge,
    // Mapped pin values
    output logic [14:0] rowPins,
    output logic [14:0] colPins
);
    // ****************************************************************
    // Mapping per bus mode
    // ****************************************************************
    logic [25:0] a;
    always_comb
    begin
        a = {physAddr, 1'b0};
        if (wideBusSelect)
        begin
            // Wide bus: everything one bit higher
            rowPins = {a[19], a[18], a[25], a[23], a[22], a[21], a[20], a[17:10]};
            colPins = {a[19], a[18], a[25], a[23], precharge, a[21], a[24], a[9:2]};
        end
        else
        begin
            rowPins = {a[18], a[17], a[24], a[22], a[21], a[20], a[19], a[16:9]};
            colPins = {a[18], a[17], a[24], a[22], precharge, a[20], a[23], a[8:1]};
        end
    end
endmodule : sbam_addr_mux

// ===== core/sbam_bank_size.sv
// Bank size register, bank decode and multiplexed SDRAM address output
//
// Contract
// - Reserved bits 15, 11, 7, 3 read zero; writes to them ignored.
// - Four three-bit size fields at 14:12, 10:8, 6:4, 2:0.
// - Codes 010/011/100 give 8/16/32 MB; 101 gives 64 MB wide only.
// - Reset loads 100 per field on 16-bit bus, 101 on 32-bit bus.
// - Row then column address driven on fifteen pins with strobes.
// - Bank selects carry bits 18,17 narrow or 19,18 wide.
// - A12, A11, A9 carry 24,22,20 narrow or 25,23,21 wide.
// - A10 carries bit 21 or 22 at row, command at column.
// - A8 carries 19/23 narrow or 20/24 wide for row/column.
// - A7..A0 carry 16..9/8..1 narrow or 17..10/9..2 wide.
// - Address comes from core or DMA unit, bits 25 down to 1.
// - Bus width input: zero selects 16-bit, one selects 32-bit map.
// - Every access ends with auto-precharge on A10 at column.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/100ps
module sbam_bank_size
    import sbam_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Configuration
    input wire logic wideBusSelect,
    // Access request from core or DMA unit
    input wire logic accessReq,
    input wire logic dmaSelect,
    input wire logic [25:1] coreAddr,
    input wire logic [25:1] dmaAddr,
    // SDRAM address pins
    output logic [14:0] sdramAddr,
    output logic rowStrobe,
    output logic colStrobe,
    output logic [NUM_BANKS-1:0] bankHit,
    output logic accessDone,
    // AXI4-Lite slave
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic [15:0] bankSize_r;
    logic strapDone_r;
    logic wideLatched_r;
    logic awTaken_r;
    logic wTaken_r;
    logic [31:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    sbam_phase_type phase_r;
    logic [25:1] addrHold_r;
    logic [14:0] rowPins;
    logic [14:0] colPins;
    logic [7:0] limit [NUM_BANKS];
    logic [7:0] addrUnits;

    // Register offset match in the decoded window
    function automatic logic hit_off(input logic [31:0] addr, input logic [31:0] off);
        return (addr & ADDR_MASK) == off;
    endfunction : hit_off

    // ****************************************************************
    // AXI4-Lite write path
    // ****************************************************************
    // Address and data taken in either order, response after both
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awTaken_r <= 1'b0;
            wTaken_r <= 1'b0;
            awAddr_r <= 32'h00000000;
            wData_r <= 32'h00000000;
            wStrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awTaken_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0; // Held item blocks the channel
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wTaken_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (awTaken_r && wTaken_r && !s_axi_bvalid)
            begin
                awTaken_r <= 1'b0;
                wTaken_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (hit_off(awAddr_r, BANK_SIZE_OFF) ||
                    hit_off(awAddr_r, STATUS_OFF)) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                // Response accepted: both channels open again
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Bank size register
    // ****************************************************************
    // Reset value follows the bus width caught after release
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bankSize_r <= 16'h0000;
            strapDone_r <= 1'b0;
            wideLatched_r <= 1'b0;
        end
        else if (!strapDone_r)
        begin
            strapDone_r <= 1'b1;
            wideLatched_r <= wideBusSelect;
            for (int i = 0; i < NUM_BANKS; i++)
            begin
                bankSize_r[i*FIELD_STRIDE +: CODE_W] <=
                    wideBusSelect ? RESET_CODE_WIDE : RESET_CODE_NARROW;
            end
        end
        else if (awTaken_r && wTaken_r && !s_axi_bvalid && hit_off(awAddr_r, BANK_SIZE_OFF))
        begin
            // Byte lanes kept; reserved bits stay zero
            if (wStrb_r[0])
                bankSize_r[7:0] <= wData_r[7:0] & WRITE_MASK[7:0];
            if (wStrb_r[1])
                bankSize_r[15:8] <= wData_r[15:8] & WRITE_MASK[15:8];
        end
    end

    // ****************************************************************
    // AXI4-Lite read path
    // ****************************************************************
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
            s_axi_arready <= 1'b1;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_arready <= 1'b0; // One read under way
            s_axi_rresp <= RESP_OKAY;
            if (hit_off(s_axi_araddr, BANK_SIZE_OFF))
                s_axi_rdata <= {16'h0000, bankSize_r & WRITE_MASK};
            else if (hit_off(s_axi_araddr, STATUS_OFF))
                s_axi_rdata <= {28'h0000000, phase_r, wideLatched_r, strapDone_r};
            else
            begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= RESP_SLVERR;
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************************************
    // Contiguous bank limits
    // ****************************************************************
    // Running sum of sizes gives each bank's upper bound
    always_comb
    begin
        logic [7:0] acc;
        acc = 8'h00;
        for (int i = 0; i < NUM_BANKS; i++)
        begin
            acc = acc + {4'h0, sbam_units(bankSize_r[i*FIELD_STRIDE +: CODE_W],
                wideLatched_r)};
            limit[i] = acc;
        end
    end
    // Address in 8 MB units: bits 25:23
    assign addrUnits = {5'h00, addrHold_r[25:23]};

    // ****************************************************************
    // Address multiplexer
    // ****************************************************************
    sbam_addr_mux u_mux (
        .physAddr(addrHold_r),
        .wideBusSelect(wideLatched_r),
        .precharge(1'b1),
        .rowPins(rowPins),
        .colPins(colPins)
    );

    // Row phase then column phase per access
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_r <= PH_IDLE;
            addrHold_r <= 25'h0000000;
            sdramAddr <= 15'h0000;
            rowStrobe <= 1'b0;
            colStrobe <= 1'b0;
            bankHit <= '0;
            accessDone <= 1'b0;
        end
        else
        begin
            rowStrobe <= 1'b0;
            colStrobe <= 1'b0;
            accessDone <= 1'b0;
            unique case (phase_r)
                PH_IDLE:
                begin
                    if (accessReq && strapDone_r)
                    begin
                        addrHold_r <= dmaSelect ? dmaAddr : coreAddr;
                        phase_r <= PH_ROW;
                    end
                end
                PH_ROW:
                begin
                    sdramAddr <= rowPins;
                    rowStrobe <= 1'b1;
                    for (int i = 0; i < NUM_BANKS; i++)
                    begin
                        bankHit[i] <= (addrUnits < limit[i]) &&
                            (i == 0 || addrUnits >= limit[i == 0 ? 0 : i-1]);
                    end
                    phase_r <= PH_COL;
                end
                PH_COL:
                begin
                    sdramAddr <= colPins;
                    colStrobe <= 1'b1;
                    accessDone <= 1'b1;
                    phase_r <= PH_IDLE;
                end
                default: phase_r <= PH_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        (bankSize_r & ~WRITE_MASK) == 16'h0000)
        else $error("reserved size bits not zero");
    a_reset_code: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(strapDone_r) |-> bankSize_r[2:0] ==
            (wideLatched_r ? RESET_CODE_WIDE : RESET_CODE_NARROW))
        else $error("bank size reset code wrong");
    a_row_then_col: assert property (@(posedge mclk) disable iff (!rst_n)
        rowStrobe |=> colStrobe && !rowStrobe)
        else $error("column phase did not follow row");
    a_col_precharge: assert property (@(posedge mclk) disable iff (!rst_n)
        colStrobe |-> sdramAddr[10])
        else $error("auto precharge missing at column");
    a_bank_sel_stable: assert property (@(posedge mclk) disable iff (!rst_n)
        rowStrobe |=> sdramAddr[14:13] == $past(sdramAddr[14:13]))
        else $error("bank select changed between phases");
    a_high_bits_stable: assert property (@(posedge mclk) disable iff (!rst_n)
        rowStrobe |=> {sdramAddr[12:11], sdramAddr[9]} ==
            {$past(sdramAddr[12:11]), $past(sdramAddr[9])})
        else $error("A12 A11 A9 changed between phases");
    a_row_low_bits: assert property (@(posedge mclk) disable iff (!rst_n)
        rowStrobe |-> sdramAddr[7:0] ==
            (wideLatched_r ? addrHold_r[17:10] : addrHold_r[16:9]))
        else $error("row low bits mismatch");
    a_col_a8: assert property (@(posedge mclk) disable iff (!rst_n)
        colStrobe |-> sdramAddr[8] == (wideLatched_r ? addrHold_r[24] : addrHold_r[23]))
        else $error("column A8 mismatch");
    a_row_a10: assert property (@(posedge mclk) disable iff (!rst_n)
        rowStrobe |-> sdramAddr[10] == (wideLatched_r ? addrHold_r[22] : addrHold_r[21]))
        else $error("row A10 mismatch");
    a_one_bank_hit: assert property (@(posedge mclk) disable iff (!rst_n)
        colStrobe |-> $countones(bankHit) <= 1)
        else $error("more than one bank selected");
endmodule : sbam_bank_size

// ===== dv/sbam_sdram_model.sv
// Passive SDRAM partner that captures row and column addresses
`timescale 1ns/100ps
module sbam_sdram_model
    import sbam_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Multiplexed address bus
    input wire logic [14:0] sdramAddr,
    input wire logic rowStrobe,
    input wire logic colStrobe,
    // Captured addresses and sticky order fault
    output logic [14:0] rowSeen,
    output logic [14:0] colSeen,
    output logic orderErr
);
    logic rowOpen = 1'b0;

    initial orderErr = 1'b0;

    // Open the row, then take the column; a column without a row is a fault
    always @(posedge mclk)
    begin
        if (rowStrobe)
        begin
            rowSeen <= sdramAddr;
            rowOpen <= 1'b1;
        end
        if (colStrobe)
        begin
            colSeen <= sdramAddr;
            rowOpen <= 1'b0; // Auto-precharge closes the row
            if (!rowOpen)
                orderErr <= 1'b1;
        end
    end
endmodule : sbam_sdram_model

// ===== dv/tb_sdram_bank_size_addr_mux.sv
// Testbench for the bank size register and SDRAM address multiplexer
`timescale 1ns/100ps
module tb_sdram_bank_size_addr_mux
    import sbam_pkg::*;
;
    logic mclk, rst_n, wideBusSelect, accessReq, dmaSelect, rowStrobe, colStrobe, accessDone;
    logic orderErr, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [25:1] coreAddr, dmaAddr;
    logic [14:0] sdramAddr, rowSeen, colSeen;
    logic [3:0] bankHit, wstrb;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [1:0] bresp, rresp;
    logic [15:0] sizeReg;
    int fails, checks;

    sbam_bank_size i_dut (.mclk(mclk), .rst_n(rst_n), .wideBusSelect(wideBusSelect),
        .accessReq(accessReq), .dmaSelect(dmaSelect), .coreAddr(coreAddr), .dmaAddr(dmaAddr),
        .sdramAddr(sdramAddr), .rowStrobe(rowStrobe), .colStrobe(colStrobe),
        .bankHit(bankHit), .accessDone(accessDone), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    sbam_sdram_model i_mem (.mclk(mclk), .sdramAddr(sdramAddr), .rowStrobe(rowStrobe),
        .colStrobe(colStrobe), .rowSeen(rowSeen), .colSeen(colSeen), .orderErr(orderErr));

    // ****************************************************************
    // Expected values
    // ****************************************************************
    // Pin map for one phase; wide mode shifts the address by one
    function automatic logic [14:0] pins(input logic [25:1] a, input logic w, input logic c);
        logic [25:0] q;
        q = {a, 1'b0} >> w;
        return {q[18], q[17], q[24], q[22], c ? 1'b1 : q[21], q[20], c ? q[23] : q[19],
            c ? q[8:1] : q[16:9]};
    endfunction : pins

    // Contiguous banks in 8 MB units, reserved codes empty
    function automatic logic [3:0] hit(input logic [25:1] a, input logic w, input logic [15:0] r);
        logic [3:0] h;
        logic [2:0] c;
        int base, u;
        h = 4'h0;
        base = 0;
        for (int i = 0; i < 4; i++)
        begin
            c = r[4*i +: 3];
            u = (c == SIZE_8MB) ? 1 : (c == SIZE_16MB) ? 2 : (c == SIZE_32MB) ? 4 :
                (c == SIZE_64MB && w) ? 8 : 0;
            if (int'(a[25:23]) >= base && int'(a[25:23]) < base + u)
                h[i] = 1'b1;
            base += u;
        end
        return h;
    endfunction : hit

    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        chk("bvalid", 32'h1, {31'h0, bvalid});
        chk("bresp", {30'h0, RESP_OKAY}, {30'h0, bresp});
        @(posedge mclk);
    endtask : axi_wr

    task automatic axi_rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
            if (arvalid && arready)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        chk("rvalid", 32'h1, {31'h0, rvalid});
        chk("rdata", e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        @(posedge mclk);
    endtask : axi_rd

    task automatic do_reset(input logic w, input logic [15:0] e);
        rst_n <= 1'b0;
        wideBusSelect <= w;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        sizeReg = e;
    endtask : do_reset

    // One access; row, column, bank and latency judged against the map
    task automatic acc(input logic [25:1] a, input logic dma);
        int n;
        n = 0;
        coreAddr <= dma ? ~a : a;
        dmaAddr <= dma ? a : ~a;
        dmaSelect <= dma;
        accessReq <= 1'b1;
        @(posedge mclk);
        accessReq <= 1'b0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (accessDone !== 1'b1 && n < 10);
        // Let the partner take the column before judging
        @(posedge mclk);
        chk("latency", 3, n);
        chk("row", {17'h0, pins(a, wideBusSelect, 1'b0)}, {17'h0, rowSeen});
        chk("col", {17'h0, pins(a, wideBusSelect, 1'b1)}, {17'h0, colSeen});
        chk("bankHit", {28'h0, hit(a, wideBusSelect, sizeReg)}, {28'h0, bankHit});
    endtask : acc

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_map();
        logic [25:1] al [5];
        al = '{25'h0155555, 25'h1234567, 25'h1aaaaaa, 25'h1ffffff, 25'h0000001};
        foreach (al[i])
            acc(al[i], i[0]);
        $display("done: map wide=%b size=%h", wideBusSelect, sizeReg);
    endtask : t_map

    task automatic t_regs(input logic [15:0] rv);
        axi_rd(BANK_SIZE_ADDR, {16'h0, rv}, RESP_OKAY);
        axi_rd(32'h0f000400, 32'h0, RESP_SLVERR);
        axi_rd(STATUS_OFF, {30'h0, wideBusSelect, 1'b1}, RESP_OKAY);
        axi_wr(BANK_SIZE_ADDR, 32'hffffbbbb);
        axi_rd(BANK_SIZE_ADDR, 32'h00003333, RESP_OKAY);
        sizeReg = 16'h3333;
        t_map();
        axi_wr(BANK_SIZE_ADDR, 32'h00002234); // Descending sizes
        axi_rd(BANK_SIZE_ADDR, 32'h00002234, RESP_OKAY);
        sizeReg = 16'h2234;
        t_map();
        $display("done: registers");
    endtask : t_regs

    task automatic close_out();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    // Clock generation
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Watchdog
    initial
    begin
        #200000;
        fails++;
        close_out();
    end

    // Main sequence
    initial
    begin
        {rst_n, wideBusSelect, accessReq, dmaSelect, awvalid, wvalid, bready} = '0;
        {arvalid, rready, coreAddr, dmaAddr, awaddr, wdata, wstrb, araddr} = '0;
        fails = 0;
        checks = 0;
        @(posedge mclk);
        do_reset(1'b0, 16'h4444);
        t_map();
        t_regs(16'h4444);
        do_reset(1'b1, 16'h5555);
        t_map();
        t_regs(16'h5555);
        chk("orderErr", 32'h0, {31'h0, orderErr});
        close_out();
    end
endmodule : tb_sdram_bank_size_addr_mux
